/* core/gsdo_regs.svh */
// gsdo_regs.svh: timing counts and frame layout for the gage serial port
// assumes a 20 MHz system clock; counts derive from times in microseconds
`ifndef GSDO_REGS_SVH
`define GSDO_REGS_SVH

// ==========================================================================
// clock and frame layout
// ==========================================================================
`define GSDO_CLK_HZ          20000000
`define GSDO_DIGITS          13
`define GSDO_DIGIT_BITS      4
`define GSDO_FRAME_BITS      52
`define GSDO_UNIT_DIGIT      12
`define GSDO_UNIT_BIT        0

// ==========================================================================
// timing (times in microseconds, counts in cycles)
// ==========================================================================
`define GSDO_HALF_US         100
`define GSDO_HALF_CYC        ((`GSDO_HALF_US * (`GSDO_CLK_HZ / 1000000)))
`define GSDO_REPEAT_US       95000
`define GSDO_REPEAT_CYC      ((`GSDO_REPEAT_US * (`GSDO_CLK_HZ / 1000000)))
`define GSDO_FIFO_DEPTH      8

`endif

/* core/gsdo_pkg.sv */
// gsdo_pkg.sv: types shared by the gage serial output port
// assumes the constants header is included by users that need counts
package gsdo_pkg;
  // ========================================================================
  // sequencer states
  // ========================================================================
  typedef enum logic [2:0] {
    GSDO_IDLE,
    GSDO_LOAD,
    GSDO_HIGH,
    GSDO_LOW,
    GSDO_DONE
  } gsdo_state_t;

  // one frame of thirteen 4-bit digits
  typedef logic [51:0] gsdo_frame_t;
endpackage

/* core/gsdo_fifo.sv */
// gsdo_fifo.sv: small flip-flop fifo between measurement source and shifter
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module gsdo_fifo #(
  parameter int WIDTH = 52,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  // fill side
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  // drain side
  output logic                  rd_valid_out,
  output logic [WIDTH-1:0]      rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  // ========================================================================
  // storage and pointers
  // ========================================================================
  logic [WIDTH-1:0] mem_reg [DEPTH];  // word storage
  logic [AW-1:0]    wr_ptr_reg;       // next write slot
  logic [AW-1:0]    rd_ptr_reg;       // next read slot
  logic [AW:0]      count_reg;        // words held
  logic             push;
  logic             pop;

  // pointer step wraps at depth, which need not be a power of two
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_reg != '0);
  assign push         = wr_valid_in & wr_ready_out;
  assign pop          = rd_valid_out & rd_ready_in;
  assign rd_data_out  = mem_reg[rd_ptr_reg];

  // write storage, no reset needed for data
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  // pointers and occupancy
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= step(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= step(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* core/gsdo_port.sv */
// gsdo_port.sv: serial measurement output port of a linear gage
// assumes a 20 MHz clock; request and origin pins are asynchronous and
// active low with external pull-ups; clock and data pins are open drain
`timescale 1ns/1ps
`default_nettype none
`include "gsdo_regs.svh"

module gsdo_port #(
  parameter int REPEAT_CYC = `GSDO_REPEAT_CYC,
  parameter int HALF_CYC   = `GSDO_HALF_CYC
) (
  // clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  // collector pins, active low, asynchronous
  input  wire logic         request_n_in,
  input  wire logic         origin_set_n_in,
  // open-drain clock line
  output logic              shift_clock_out,
  output logic              shift_clock_oe_out,
  // open-drain data line
  output logic              data_out,
  output logic              data_oe_out,
  // measurement source
  input  wire logic         meas_valid_in,
  input  wire logic [47:0]  meas_digits_in,
  input  wire logic         meas_inch_in,
  output logic              meas_ready_out,
  // origin-set event to the gage core, and port busy flag
  output logic              origin_pulse_out,
  output logic              busy_out
);
  // ========================================================================
  // input synchronisers, three stages, change counted when 1 and 2 agree
  // ========================================================================
  logic [2:0] req_sync_reg;   // request pin stages
  logic [2:0] org_sync_reg;   // origin pin stages
  logic       req_act_reg;    // filtered request, high when asserted
  logic       org_act_reg;    // filtered origin, high when asserted
  logic       org_prev_reg;   // for origin edge

  // sample pins; stage 0 is read only by stage 1
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      req_sync_reg <= 3'h7;
      org_sync_reg <= 3'h7;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], request_n_in};
      org_sync_reg <= {org_sync_reg[1:0], origin_set_n_in};
    end
  end

  // accept a level once stages 1 and 2 agree
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      req_act_reg  <= 1'b0;
      org_act_reg  <= 1'b0;
      org_prev_reg <= 1'b0;
    end else begin
      if (req_sync_reg[1] == req_sync_reg[2]) begin
        req_act_reg <= ~req_sync_reg[2];
      end
      if (org_sync_reg[1] == org_sync_reg[2]) begin
        org_act_reg <= ~org_sync_reg[2];
      end
      org_prev_reg <= org_act_reg;
    end
  end

  // origin event is forwarded to the gage core as one pulse
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      origin_pulse_out <= 1'b0;
    end else begin
      origin_pulse_out <= org_act_reg & ~org_prev_reg;
    end
  end

  // ========================================================================
  // measurement fifo, its ready output stalls the source when full
  // ========================================================================
  gsdo_pkg::gsdo_frame_t src_frame;   // frame assembled from source
  gsdo_pkg::gsdo_frame_t fifo_frame;  // oldest queued frame
  logic                  fifo_valid;  // fifo holds a frame
  logic                  fifo_pop;    // shifter takes a frame

  assign src_frame = {3'h0, meas_inch_in, meas_digits_in};

  gsdo_fifo #(
    .WIDTH (`GSDO_FRAME_BITS),
    .DEPTH (`GSDO_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .wr_valid_in  (meas_valid_in),
    .wr_data_in   (src_frame),
    .wr_ready_out (meas_ready_out),
    .rd_valid_out (fifo_valid),
    .rd_data_out  (fifo_frame),
    .rd_ready_in  (fifo_pop)
  );

  // ========================================================================
  // frame sequencer
  // ========================================================================
  localparam int HALF = HALF_CYC;  // half period, must fit the 12-bit timer
  gsdo_pkg::gsdo_state_t state_reg;       // sequencer state
  gsdo_pkg::gsdo_frame_t shift_reg;       // frame being sent
  logic [5:0]            bit_cnt_reg;     // bits already sent
  logic [11:0]           half_cnt_reg;    // half-period timer
  logic [31:0]           repeat_cnt_reg;  // frame-to-frame spacing
  logic                  clk_low_reg;     // clock line pulled low
  logic                  data_low_reg;    // data line pulled low
  logic                  half_done;
  logic                  repeat_done;

  assign half_done   = (half_cnt_reg == 12'(HALF - 1));
  assign repeat_done = (repeat_cnt_reg == '0);
  assign fifo_pop    = (state_reg == gsdo_pkg::GSDO_LOAD) & fifo_valid;

  // state transitions and bit counting
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg   <= gsdo_pkg::GSDO_IDLE;
      bit_cnt_reg <= 6'h00;
      shift_reg   <= '0;
    end else begin
      case (state_reg)
        gsdo_pkg::GSDO_IDLE: begin
          if (req_act_reg && !org_act_reg && repeat_done) begin
            state_reg <= gsdo_pkg::GSDO_LOAD;
          end
        end
        gsdo_pkg::GSDO_LOAD: begin
          // wait for a measurement; an empty fifo holds the frame back
          if (fifo_valid) begin
            shift_reg   <= fifo_frame;
            bit_cnt_reg <= 6'h00;
            state_reg   <= gsdo_pkg::GSDO_HIGH;
          end
        end
        gsdo_pkg::GSDO_HIGH: begin
          if (half_done) begin
            state_reg <= gsdo_pkg::GSDO_LOW;
          end
        end
        gsdo_pkg::GSDO_LOW: begin
          if (half_done) begin
            shift_reg   <= {1'b0, shift_reg[51:1]};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == 6'(`GSDO_FRAME_BITS - 1)) begin
              state_reg <= gsdo_pkg::GSDO_DONE;
            end else begin
              state_reg <= gsdo_pkg::GSDO_HIGH;
            end
          end
        end
        gsdo_pkg::GSDO_DONE: begin
          state_reg <= gsdo_pkg::GSDO_IDLE;
        end
        default: begin
          state_reg <= gsdo_pkg::GSDO_IDLE;
        end
      endcase
    end
  end

  // half-period timer, restarts on each phase change
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      half_cnt_reg <= 12'h000;
    end else if ((state_reg == gsdo_pkg::GSDO_HIGH ||
                  state_reg == gsdo_pkg::GSDO_LOW) && !half_done) begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end else begin
      half_cnt_reg <= 12'h000;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      repeat_cnt_reg <= 32'h0;
    end else if (state_reg == gsdo_pkg::GSDO_LOAD && fifo_valid) begin
      repeat_cnt_reg <= 32'(REPEAT_CYC - 1);
    end else if (!repeat_done) begin
      repeat_cnt_reg <= repeat_cnt_reg - 1'b1;
    end
  end

  // ========================================================================
  // line drivers
  // ========================================================================
  // device drives clock and data
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clk_low_reg  <= 1'b0;
      data_low_reg <= 1'b0;
    end else begin
      clk_low_reg <= (state_reg == gsdo_pkg::GSDO_LOW);
      // wait one cycle after the release so data never moves with the edge
      // data set once clock high
      if (state_reg == gsdo_pkg::GSDO_HIGH && !clk_low_reg) begin
        data_low_reg <= ~shift_reg[0];
      end else if (state_reg == gsdo_pkg::GSDO_IDLE) begin
        data_low_reg <= 1'b0;
      end
    end
  end

  // open drain: output enable pulls the line low, pull-up gives high
  assign shift_clock_out    = 1'b0;
  assign shift_clock_oe_out = clk_low_reg;
  assign data_out           = 1'b0;
  assign data_oe_out        = data_low_reg;
  assign busy_out           = (state_reg != gsdo_pkg::GSDO_IDLE);
endmodule
`default_nettype wire

/* dv/gsdo_collector.sv */
// gsdo_collector.sv: behavioural collector on the far side of the link
// assumes the bench resolves the open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
// ====================
// frame collector
// ====================
module gsdo_collector (
  // resolved link lines
  input  wire logic                clock_line_in,
  input  wire logic                data_line_in,
  // assembled frame, short pulse each frame
  output var gsdo_pkg::gsdo_frame_t frame_out,
  output logic                     frame_valid_out
);
  int                    n_bits;    // bits gathered so far
  gsdo_pkg::gsdo_frame_t shift_reg; // lsb arrives first
  initial begin
    n_bits = 0;
    shift_reg = '0;
    frame_out = '0;
    frame_valid_out = 1'b0;
  end
  // sample well inside the low phase, never while high
  always @(negedge clock_line_in) begin
    #100;
    shift_reg = {data_line_in, shift_reg[51:1]};
    n_bits++;
    if (n_bits == 52) begin
      n_bits = 0;
      frame_out = shift_reg;
      frame_valid_out = 1'b1;
      #100;
      frame_valid_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* dv/gsdo_port_checker.sv */
// gsdo_port_checker.sv: pin timing checks for gsdo_port
// assumes only the top module's ports; bound at the file's foot
`timescale 1ns/1ps
`default_nettype none
`include "gsdo_regs.svh"
// ====================
// checker
// ====================
module gsdo_port_checker #(
  parameter int REPEAT_CYC = 5000,
  parameter int HALF_CYC   = 4
) (
  input wire logic sys_clk_in, reset_in, request_n_in, origin_set_n_in,
  input wire logic shift_clock_out, shift_clock_oe_out, data_out,
  input wire logic data_oe_out, meas_valid_in, meas_inch_in,
  input wire logic [47:0] meas_digits_in,
  input wire logic meas_ready_out, origin_pulse_out, busy_out
);
  int lo_cnt_reg;  // cycles the clock line sat low
  int hi_cnt_reg;  // busy cycles the clock line stood high
  int edge_cnt_reg; // falling clock edges in this frame
  int gap_cnt_reg; // cycles since frame start, saturating
  // half-period and edge counters; cleared while idle
  always_ff @(posedge sys_clk_in) begin
    lo_cnt_reg <= shift_clock_oe_out ? lo_cnt_reg + 1 : 0;
    hi_cnt_reg <= (busy_out && !shift_clock_oe_out) ? hi_cnt_reg + 1 : 0;
    edge_cnt_reg <= !busy_out ? 0
                  : edge_cnt_reg + int'($rose(shift_clock_oe_out));
  end
  // saturate so a long idle never wraps
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      gap_cnt_reg <= REPEAT_CYC;
    end else if ($rose(busy_out)) begin
      gap_cnt_reg <= 1;
    end else if (gap_cnt_reg < REPEAT_CYC) begin
      gap_cnt_reg <= gap_cnt_reg + 1;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  pins_drain_a: assert property (!shift_clock_out && !data_out)
    else $error("open-drain pin driven high");
  clock_idle_a: assert property (!busy_out |-> !shift_clock_oe_out)
    else $error("clock line low while idle");
  data_settle_a: assert property ($changed(data_oe_out) |->
    !shift_clock_oe_out && !$past(shift_clock_oe_out))
    else $error("data moved while clock low");
  low_half_a: assert property ($fell(shift_clock_oe_out) |->
    lo_cnt_reg == HALF_CYC) else $error("low half wrong length");
  high_half_a: assert property ($rose(shift_clock_oe_out) |->
    hi_cnt_reg >= HALF_CYC && hi_cnt_reg <= HALF_CYC + 2)
    else $error("high half wrong length");
  frame_bits_a: assert property ($fell(busy_out) |->
    edge_cnt_reg == `GSDO_FRAME_BITS) else $error("frame bit count");
  frame_gap_a: assert property ($rose(busy_out) |->
    gap_cnt_reg >= REPEAT_CYC) else $error("frames too close");
  origin_seen_a: assert property ($fell(origin_set_n_in) |->
    ##[1:8] origin_pulse_out) else $error("origin pulse missing");
  origin_once_a: assert property (origin_pulse_out |=>
    !origin_pulse_out) else $error("origin pulse too long");
  frame_c: cover property ($fell(busy_out));
  origin_c: cover property (origin_pulse_out);
  full_c: cover property (meas_valid_in && !meas_ready_out);
endmodule
bind gsdo_port gsdo_port_checker #(.REPEAT_CYC(REPEAT_CYC),
  .HALF_CYC(HALF_CYC)) u_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .request_n_in(request_n_in), .origin_set_n_in(origin_set_n_in),
  .shift_clock_out(shift_clock_out), .data_out(data_out),
  .shift_clock_oe_out(shift_clock_oe_out), .data_oe_out(data_oe_out),
  .meas_valid_in(meas_valid_in), .meas_inch_in(meas_inch_in),
  .meas_digits_in(meas_digits_in), .meas_ready_out(meas_ready_out),
  .origin_pulse_out(origin_pulse_out), .busy_out(busy_out));
`default_nettype wire

/* dv/gsdo_port_test.sv */
// gsdo_port_test.sv: self-checking bench for the gage serial port
// assumes the collector model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench top
// ====================
module gsdo_port_test;
  localparam int REPEAT_CYC = 5000; // short so held requests repeat soon
  localparam int HALF_CYC = 4; // 400 ns link clock keeps frames short
  logic sys_clk_in, reset_in, request_n_in, origin_set_n_in, frame_valid;
  logic meas_valid_in, meas_inch_in, meas_ready_out, busy_out;
  logic shift_clock_out, shift_clock_oe_out, data_out, data_oe_out;
  logic origin_pulse_out, clock_line, data_line;
  logic [47:0] meas_digits_in;
  gsdo_pkg::gsdo_frame_t got_frame;
  gsdo_pkg::gsdo_frame_t exp_q[$]; // frames in send order
  int n_mismatch, comparisons, cycles;
  int seed = 32'h32ee5177;
  // pull-ups hold both lines high when released
  assign clock_line = shift_clock_oe_out ? shift_clock_out : 1'b1;
  assign data_line = data_oe_out ? data_out : 1'b1;
  gsdo_port #(.REPEAT_CYC(REPEAT_CYC), .HALF_CYC(HALF_CYC)) u_gsdo_port (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .request_n_in(request_n_in), .origin_set_n_in(origin_set_n_in),
    .shift_clock_out(shift_clock_out), .data_out(data_out),
    .shift_clock_oe_out(shift_clock_oe_out), .data_oe_out(data_oe_out),
    .meas_valid_in(meas_valid_in), .meas_digits_in(meas_digits_in),
    .meas_inch_in(meas_inch_in), .meas_ready_out(meas_ready_out),
    .origin_pulse_out(origin_pulse_out), .busy_out(busy_out));
  gsdo_collector u_gsdo_collector (
    .clock_line_in(clock_line), .data_line_in(data_line),
    .frame_out(got_frame), .frame_valid_out(frame_valid));
  task automatic check(input string what, input logic [51:0] seen,
                       input logic [51:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #2;
  endtask
  // offer one frame, held until taken; caller drops valid
  task automatic offer(input logic inch);
    meas_valid_in = 1'b1;
    meas_inch_in = inch;
    meas_digits_in = 48'({$random(seed), $random(seed)});
    do @(posedge sys_clk_in); while (meas_ready_out !== 1'b1);
    exp_q.push_back({3'h0, inch, meas_digits_in});
    #2;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // hang guard: the whole run needs about 16000 cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // each collected frame meets the oldest note
  always @(posedge frame_valid) begin
    check("frame", got_frame, exp_q.size() ? exp_q.pop_front() : 52'hx);
  end
  initial begin
    reset_in = 1'b1;
    request_n_in = 1'b1;
    origin_set_n_in = 1'b1;
    meas_valid_in = 1'b0;
    meas_inch_in = 1'b0;
    meas_digits_in = 48'h0;
    step(12);
    reset_in = 1'b0;
    check("reset", 52'({busy_out, shift_clock_oe_out, meas_ready_out}),
          52'h1);
    // settle time before driving the pins
    step(4);
    // request stays high while origin is set
    origin_set_n_in = 1'b0;
    step(20);
    origin_set_n_in = 1'b1;
    // both unit codes, then a ninth word that must be refused
    for (int i = 0; i < 8; i++) offer(i[0]);
    meas_digits_in = 48'({$random(seed), $random(seed)});
    step(10);
    check("full", 52'(meas_ready_out), 52'h0);
    meas_valid_in = 1'b0;
    request_n_in = 1'b0;
    wait (exp_q.size() == 7);
    step(1);
    check("ready", 52'(meas_ready_out), 52'h1);
    wait (busy_out === 1'b0);
    wait (busy_out === 1'b1);
    step(1);
    request_n_in = 1'b1;
    wait (exp_q.size() == 6);
    step(REPEAT_CYC * 2);
    check("idle", 52'({busy_out, exp_q.size() == 6}), 52'h1);
    complete_run();
  end
endmodule
`default_nettype wire
